//--- design/ssf_regs.vh
// Constants for the shared serial flash slave front end.
// Assumes inclusion by the slave top only; the receive FIFO takes its depth as a parameter.
`ifndef SSF_REGS_VH
`define SSF_REGS_VH

// ----------------------------------------------------------------------
// Field widths, queue depth and reset values
// ----------------------------------------------------------------------
`define SSF_BYTE_W      4'h8
`define SSF_FIFO_DEPTH  8
`define SSF_SYNC_RST    3'h7
`define SSF_CLK_RST     3'h0
`define SSF_TX_RST      8'hff

// ----------------------------------------------------------------------
// Bit counter values at the ends of a byte, MSB first
// ----------------------------------------------------------------------
`define SSF_FIRST_BIT   3'h0
`define SSF_LAST_BIT    3'h7

`endif

//--- design/ssf_fifo.v
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ssf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_r;
    reg [AW-1:0]    rd_r;
    reg [AW:0]      cnt_r;
    wire            push;
    wire            pop;

    // Full and empty come straight from the fill count.
    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = mem[rd_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers and count advance on accepted transfers.
    always @(posedge clk) begin
        if (reset) begin
            wr_r  <= {AW{1'b0}};
            rd_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                        : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                        : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // Storage write.
    always @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

endmodule

//--- design/ssf_slave.v
// Serial flash slave front end: shifts bytes in and out over the
// shared four-wire bus and queues received bytes for the flash core.
// Assumes the serial clock and select come from an outside master and
// are oversampled by CLK, at least four CLK periods per serial phase.
// Assumes the master idles the serial clock low between frames and that
// the flash core holds the next reply byte on TX_DATA ahead of each byte
// boundary; TX_TAKE then says that byte has been taken.
// A byte cut short by a rising select is dropped, never queued, and a
// byte that meets a full receive queue is lost and flagged.
//
// Overview of operation
// - Each data input bit is captured at a rising serial clock edge.
// - Each output bit after a frame's first is shifted onto the data output at a falling clock edge.
// - With select high the slave is idle and its output is released; low enables it.
// - Only the documented ownership patterns of the shared bus are supported.
`timescale 1ns/1ps
`include "ssf_regs.vh"
module ssf_slave #(
    parameter DEPTH = `SSF_FIFO_DEPTH,
    parameter AW    = 3
) (
    input  wire       CLK,
    input  wire       RESET,
    input  wire       SCK,
    input  wire       SEL_N,
    input  wire       MOSI,
    output wire       MISO_O,
    output wire       MISO_OE,
    output wire [7:0] RX_DATA,
    output wire       RX_VALID,
    input  wire       RX_READY,
    output wire       RX_OVERRUN,
    input  wire [7:0] TX_DATA,
    output wire       TX_TAKE,
    output wire       FRAME_START,
    output wire       ARMED
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    reg  [2:0] sck_r;
    reg  [2:0] sel_r;
    reg  [2:0] mosi_r;
    reg        sck_st_r;
    reg        sel_st_r;
    reg        mosi_st_r;
    wire       sck_rise;
    wire       sck_fall;
    wire       sel_fall;

    // Three stages per pin; a change counts once stages two and three agree.
    always @(posedge CLK) begin
        if (RESET) begin
            sck_r     <= `SSF_CLK_RST;
            sel_r     <= `SSF_SYNC_RST;
            mosi_r    <= `SSF_CLK_RST;
            sck_st_r  <= 1'b0;
            sel_st_r  <= 1'b1;
            mosi_st_r <= 1'b0;
        end else begin
            sck_r  <= {sck_r[1:0], SCK};
            sel_r  <= {sel_r[1:0], SEL_N};
            mosi_r <= {mosi_r[1:0], MOSI};
            if (sck_r[1] == sck_r[2]) begin
                sck_st_r <= sck_r[2];
            end
            if (sel_r[1] == sel_r[2]) begin
                sel_st_r <= sel_r[2];
            end
            if (mosi_r[1] == mosi_r[2]) begin
                mosi_st_r <= mosi_r[2];
            end
        end
    end

    // Edges of the settled serial clock and select.
    assign sck_rise = (sck_r[1] == sck_r[2]) & sck_r[2] & ~sck_st_r;
    assign sck_fall = (sck_r[1] == sck_r[2]) & ~sck_r[2] & sck_st_r;
    assign sel_fall = (sel_r[1] == sel_r[2]) & ~sel_r[2] & sel_st_r;

    // ------------------------------------------------------------------
    // Frame control
    // ------------------------------------------------------------------
    reg        armed_r;
    reg        active_r;
    reg        start_r;
    reg  [2:0] bit_r;
    reg  [7:0] rx_sh_r;
    reg  [7:0] tx_sh_r;
    reg        miso_r;
    reg        push_r;
    reg  [7:0] push_data_r;
    reg        ovr_r;
    reg        take_r;
    wire       fifo_in_ready;

    // Bit counter values at the ends of a byte on the wire.
    localparam [2:0] LAST_BIT  = `SSF_LAST_BIT;
    localparam [2:0] FIRST_BIT = `SSF_FIRST_BIT;

    // Arming waits for the first falling select after reset.
    // A frame runs while select stays low after arming.
    always @(posedge CLK) begin
        if (RESET) begin
            armed_r  <= 1'b0;
            active_r <= 1'b0;
            start_r  <= 1'b0;
        end else begin
            start_r <= 1'b0;
            if (sel_fall) begin
                armed_r  <= 1'b1;
                active_r <= 1'b1;
                start_r  <= 1'b1;
            end else if (sel_st_r) begin
                active_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    // Receive shifter: one bit per rising serial clock edge.
    // A partial byte left when select rises is cleared with the shifter.
    always @(posedge CLK) begin
        if (RESET || !active_r) begin
            bit_r       <= 3'h0;
            rx_sh_r     <= 8'h00;
            push_r      <= 1'b0;
            push_data_r <= 8'h00;
        end else begin
            push_r <= 1'b0;
            if (sck_rise) begin
                rx_sh_r <= {rx_sh_r[6:0], mosi_st_r};
                bit_r   <= bit_r + 3'h1;
                if (bit_r == LAST_BIT) begin
                    push_r      <= 1'b1;
                    push_data_r <= {rx_sh_r[6:0], mosi_st_r};
                end
            end
        end
    end

    // Overrun is sticky until the next frame; a byte lost wins a clear.
    always @(posedge CLK) begin
        if (RESET) begin
            ovr_r <= 1'b0;
        end else if (push_r && !fifo_in_ready) begin
            ovr_r <= 1'b1;
        end else if (start_r) begin
            ovr_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------------
    // Transmit shifter: next bit appears at each falling clock edge.
    // The first bit stands from frame start, before the first clock edge.
    always @(posedge CLK) begin
        if (RESET) begin
            tx_sh_r <= `SSF_TX_RST;
            miso_r  <= 1'b1;
            take_r  <= 1'b0;
        end else begin
            take_r <= 1'b0;
            if (start_r) begin
                tx_sh_r <= TX_DATA;
                miso_r  <= TX_DATA[7];
                take_r  <= 1'b1;
            end else if (active_r && sck_fall) begin
                if (bit_r == FIRST_BIT) begin
                    tx_sh_r <= TX_DATA;
                    miso_r  <= TX_DATA[7];
                    take_r  <= 1'b1;
                end else begin
                    tx_sh_r <= {tx_sh_r[6:0], 1'b1};
                    miso_r  <= tx_sh_r[6];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Serial output, driven only while selected after arming and
    // released otherwise, so that the other master may own the line.
    assign MISO_O      = miso_r;
    assign MISO_OE     = active_r & ~sel_st_r;

    // Handshake and status outputs, each straight from a flip-flop.
    assign TX_TAKE     = take_r;
    assign FRAME_START = start_r;
    assign ARMED       = armed_r;
    assign RX_OVERRUN  = ovr_r;

    // ------------------------------------------------------------------
    // Receive queue
    // ------------------------------------------------------------------
    ssf_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .clk       (CLK),
        .reset     (RESET),
        .in_data   (push_data_r),
        .in_valid  (push_r),
        .in_ready  (fifo_in_ready),
        .out_data  (RX_DATA),
        .out_valid (RX_VALID),
        .out_ready (RX_READY)
    );

endmodule

//--- dv/ssf_slave_asserts.sv
// Port checker for the serial flash slave front end.
// Assumes a bind onto ssf_slave; it reads the ports only.
`timescale 1ns/1ps
module ssf_slave_asserts (
    input wire CLK,
    input wire RESET,
    input wire SCK,
    input wire SEL_N,
    input wire MISO_O,
    input wire MISO_OE,
    input wire RX_VALID,
    input wire RX_OVERRUN,
    input wire TX_TAKE,
    input wire FRAME_START,
    input wire ARMED
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    // Output off when deselected, steady in a high clock phase.
    property p_oe_idle;
        SEL_N [*6] |-> !MISO_OE;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("output on while deselected");
    property p_out_hold;
        SCK [*2] |-> $stable(MISO_O);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("output moved in high phase");
    property p_byte_rise;
        $rose(RX_VALID) |-> $past(SCK, 5);
    endproperty
    a_byte_rise: assert property (p_byte_rise)
        else $error("byte without rising edge");
    // Output enabled only at an armed frame start; reply byte taken next.
    property p_oe_start;
        $rose(MISO_OE) |-> FRAME_START && ARMED;
    endproperty
    a_oe_start: assert property (p_oe_start)
        else $error("output on outside a frame start");
    property p_take_start;
        FRAME_START |=> TX_TAKE;
    endproperty
    a_take_start: assert property (p_take_start)
        else $error("reply byte not taken at frame start");
    // Frame opened, byte lost, output released.
    c_frame: cover property (FRAME_START);
    c_overrun: cover property ($rose(RX_OVERRUN));
    c_release: cover property ($fell(MISO_OE));
endmodule

bind ssf_slave ssf_slave_asserts u_chk (.CLK(CLK), .RESET(RESET),
    .SCK(SCK), .SEL_N(SEL_N), .MISO_O(MISO_O), .MISO_OE(MISO_OE),
    .RX_VALID(RX_VALID), .RX_OVERRUN(RX_OVERRUN), .TX_TAKE(TX_TAKE),
    .FRAME_START(FRAME_START), .ARMED(ARMED));

//--- dv/ssf_spi_master.sv
// Serial master model standing for the owner of the flash bus.
// Assumes the slave oversamples these pins with its own clock.
`timescale 1ns/1ps
module ssf_spi_master (
    output logic sck,
    output logic sel_n,
    output logic mosi,
    input  wire  miso,
    input  wire  miso_oe
);
    // Pins idle with the clock low and the select high. This model is
    // the only driver of sck, sel_n and mosi, none of which serves as
    // general I/O; the slave drives miso.
    initial {sck, sel_n, mosi} = 3'b010;
    // Moves the select; on release the data line shows the inverse.
    task sel(logic v);
        #80 sel_n = v;
        if (v) mosi = ~mosi;
        #80;
    endtask
    // Sends n bits MSB first and takes the reply at each rising edge.
    task shift(logic [7:0] d, int n, output logic [7:0] q);
        for (int i = 0; i < n; i++) begin
            mosi = d[7 - i];
            #80 sck = 1'b1;
            q = {q[6:0], miso_oe ? miso : ~miso};
            #80 sck = 1'b0;
        end
    endtask
endmodule

//--- dv/shared_spi_flash_access_tb.sv
// Self-checking bench for the serial flash slave front end.
// Assumes the master model paces the pins at a 160 ns period.
`timescale 1ns/1ps
module shared_spi_flash_access_tb;
    logic       clk = 1'b0, reset = 1'b1, rx_ready = 1'b0;
    logic [7:0] tx_data = 8'hc5, q, rx_data;
    logic       sck, sel_n, mosi, miso_o, miso_oe, rx_valid, ovr, armed;
    int         fail_count = 0, compares = 0;
    // Free-running clock.
    always #2.5 clk = ~clk;
    ssf_slave DUT (.CLK(clk), .RESET(reset), .SCK(sck), .SEL_N(sel_n),
        .MOSI(mosi), .MISO_O(miso_o), .MISO_OE(miso_oe), .RX_DATA(rx_data),
        .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_OVERRUN(ovr),
        .TX_DATA(tx_data), .TX_TAKE(), .FRAME_START(), .ARMED(armed));
    ssf_spi_master mst (.sck(sck), .sel_n(sel_n), .mosi(mosi),
        .miso(miso_o), .miso_oe(miso_oe));
    task chk(string s, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", s, e, g);
            fail_count++;
        end
    endtask
    task pop(logic [7:0] e);
        for (int n = 0; n < 40 && rx_valid !== 1'b1; n++) @(posedge clk) #1;
        chk("rx_valid", 8'h01, {7'h0, rx_valid});
        chk("rx_data", e, rx_data);
        rx_ready = 1'b1;
        @(posedge clk) #1 rx_ready = 1'b0;
        @(posedge clk) #1;
    endtask
    task report_and_stop();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One frame of instruction and address; the preset byte returns.
    task t_cmd();
        chk("idle", 8'h00, {6'h0, armed, miso_oe});
        mst.sel(1'b0);
        chk("select", 8'h03, {6'h0, armed, miso_oe});
        for (int i = 0; i < 3; i++) mst.shift(8'hfe >> (3 * i), 8, q);
        chk("reply", 8'hc5, q);
        mst.sel(1'b1);
        for (int i = 0; i < 3; i++) pop(8'hfe >> (3 * i));
    endtask
    // Nine bytes into a stalled queue: the ninth is lost, eight drain.
    task t_over();
        mst.sel(1'b0);
        for (int i = 0; i < 9; i++) mst.shift(8'h40 + 8'(i), 8, q);
        mst.sel(1'b1);
        chk("overrun", 8'h01, {7'h0, ovr});
        for (int i = 0; i < 8; i++) pop(8'h40 + 8'(i));
        chk("released", 8'h00, {6'h0, miso_oe, rx_valid});
    endtask
    // A fresh frame clears the overrun and returns a new preset byte.
    task t_clear();
        tx_data = 8'h3c;
        mst.sel(1'b0);
        chk("ovr_clear", 8'h00, {7'h0, ovr});
        mst.shift(8'ha5, 8, q);
        chk("reply2", 8'h3c, q);
        mst.sel(1'b1);
        pop(8'ha5);
    endtask
    // Mid-run reset drops a queued byte and disarms until select falls.
    task t_reset();
        mst.sel(1'b0);
        mst.shift(8'h5a, 8, q);
        mst.sel(1'b1);
        reset = 1'b1;
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        chk("rst_idle", 8'h00, {5'h0, armed, miso_oe, rx_valid});
        mst.sel(1'b0);
        chk("rearm", 8'h03, {6'h0, armed, miso_oe});
        mst.shift(8'h96, 8, q);
        mst.sel(1'b1);
        pop(8'h96);
    endtask
    // Holds reset for ten cycles, then runs the scenarios.
    initial begin
        repeat (10) @(posedge clk);
        #1 reset = 1'b0;
        t_cmd();
        t_over();
        t_clear();
        t_reset();
        report_and_stop();
    end
    // Cuts a hang short at about five times the expected 21 us run.
    initial begin
        #100000 fail_count++;
        report_and_stop();
    end
endmodule
